//--- lpm_line_monitor.sv
// DS3/E3 line configuration, condition word and current-interval counters
//
// Design decisions made here: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module lpm_line_monitor #(
  parameter longint SEC_CYCLES_P = lpm_pkg::SEC_CYCLES
) (
  // clock and reset
  input  wire logic                CLK,
  input  wire logic                RST_B,
  // AHB-Lite slave
  input  wire logic                HSEL,
  input  wire logic [31:0]         HADDR,
  input  wire logic [1:0]          HTRANS,
  input  wire logic                HWRITE,
  input  wire logic [2:0]          HSIZE,
  input  wire logic [31:0]         HWDATA,
  input  wire logic                HREADY,
  output logic [31:0]              HRDATA,
  output logic                     HREADYOUT,
  output logic                     HRESP,
  // line indications
  input  wire lpm_pkg::line_evt_t  LINE_EVT,
  // line control
  output lpm_pkg::line_mode_t      LINE_MODE,
  output logic                     PAYLOAD_LOOP_EN,
  output logic                     LINE_LOOP_EN,
  output logic                     TX_CLK_RECOVERED,
  output logic                     INTERVAL_DONE
);
  import lpm_pkg::*;

  typedef struct packed {
    bus_req_t    req;
    logic [31:0] rdata;
    line_mode_t  mode;
    logic [2:0]  loopback_select;
    logic [1:0]  tx_timing_select;
    logic [2:0]  cfg_err;
    logic [15:0] line_interface_index;
    logic [15:0] cur_interface_index;
    sec_acc_t    acc;
    logic [NUM_CNT-1:0][31:0] cnt;
    logic        pl_loop;
    logic        ln_loop;
    logic        tx_rec;
    logic        int_done;
  } state_t;

  state_t q, d;
  logic       sec_tick;
  logic       int_tick;
  logic [9:0] secs_done;
  logic [7:0] cond_word;
  logic       oof_now;

  lpm_sec_timer #(
    .SEC_CYCLES_P (SEC_CYCLES_P)
  ) u_timer (
    .CLK       (CLK),
    .RST_B     (RST_B),
    .SEC_TICK  (sec_tick),
    .INT_TICK  (int_tick),
    .SECS_DONE (secs_done)
  );

  function automatic logic [31:0] inc_sat(input logic [31:0] v, input logic en);
    logic [31:0] r;
    r = v;
    if (en && v != 32'hFFFF_FFFF) begin
      r = v + 32'h0000_0001;
    end
    return r;
  endfunction

  function automatic logic [7:0] inc8(input logic [7:0] v, input logic en);
    logic [7:0] r;
    r = v;
    if (en && v != 8'hFF) begin
      r = v + 8'h01;
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // condition word

  assign oof_now = LINE_EVT.lof;

  always_comb begin
    cond_word = 8'h00;
    if (q.acc.rai || LINE_EVT.rx_rai) begin
      cond_word = cond_word | COND_RX_RAI;
    end
    if (LINE_EVT.tx_rai) begin
      cond_word = cond_word | COND_TX_RAI;
    end
    if (LINE_EVT.ais) begin
      cond_word = cond_word | COND_RX_AIS;
    end
    if (LINE_EVT.lof) begin
      cond_word = cond_word | COND_LOF;
    end
    if (LINE_EVT.los) begin
      cond_word = cond_word | COND_LOS;
    end
    if ((cond_word & ~COND_LOOP) == 8'h00) begin
      cond_word = cond_word | COND_NO_ALARM;
    end
    if (q.pl_loop || q.ln_loop) begin
      cond_word = cond_word | COND_LOOP;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic        ds3;
    logic        cbit;
    logic        wr;
    logic [7:0]  wa;
    logic [31:0] sel;
    logic        prev_sec_err;
    ds3 = 1'b0;
    cbit = 1'b0;
    wr = 1'b0;
    wa = 8'h00;
    sel = 32'h0000_0000;
    prev_sec_err = 1'b0;
    d = q;
    d.int_done = int_tick;
    ds3  = (q.mode != MODE_E3);
    cbit = (q.mode == MODE_DS3_CBIT);

    // bus address phase
    d.req.hit   = HSEL && HREADY && HTRANS[1];
    d.req.write = HWRITE;
    d.req.addr  = HADDR[7:0];
    wr = q.req.hit && q.req.write;
    wa = q.req.addr;

    if (wr) begin
      case (wa)
        OFS_LINE_CFG: begin
          if (HWDATA[1:0] == MODE_DS3_M13 || HWDATA[1:0] == MODE_DS3_CBIT ||
              HWDATA[1:0] == MODE_E3) begin
            d.mode = line_mode_t'(HWDATA[1:0]);
          end else begin
            d.cfg_err[ERR_MODE_BIT] = 1'b1;
          end
        end
        OFS_LOOP_SEL: begin
          case (HWDATA[2:0])
            LOOP_NONE: begin
              d.loopback_select = LOOP_NONE;
              d.pl_loop = 1'b0;
              d.ln_loop = 1'b0;
            end
            LOOP_PAYLOAD: begin
              d.loopback_select = LOOP_PAYLOAD;
              d.pl_loop = 1'b1;
              d.ln_loop = 1'b0;
            end
            LOOP_LINE: begin
              d.loopback_select = LOOP_LINE;
              d.pl_loop = 1'b0;
              d.ln_loop = 1'b1;
            end
            default: begin
              d.cfg_err[ERR_LOOP_BIT] = 1'b1;
            end
          endcase
        end
        OFS_TX_TIMING: begin
          if (HWDATA[1:0] == TIMING_RECOVERED || HWDATA[1:0] == TIMING_INTERNAL) begin
            d.tx_timing_select = HWDATA[1:0];
            d.tx_rec = (HWDATA[1:0] == TIMING_RECOVERED);
          end else begin
            d.cfg_err[ERR_TIMING_BIT] = 1'b1;
          end
        end
        OFS_CFG_ERR: begin
          d.cfg_err = q.cfg_err & ~HWDATA[2:0];
        end
        OFS_IFACE_IDX: begin
          d.line_interface_index = HWDATA[15:0];
        end
        default: begin
        end
      endcase
    end

    // tagging of the counter set
    d.cur_interface_index = d.line_interface_index;

    // within-second accumulation
    d.acc.lcv = q.acc.lcv | LINE_EVT.line_cv;
    d.acc.pcv = q.acc.pcv | LINE_EVT.parity_cv;
    d.acc.ccv = q.acc.ccv | LINE_EVT.cbit_cv;
    d.acc.oof = q.acc.oof | oof_now;
    d.acc.ais = q.acc.ais | LINE_EVT.ais;
    d.acc.rai = q.acc.rai | LINE_EVT.rx_rai;
    d.acc.pcv_cnt = inc8(q.acc.pcv_cnt, LINE_EVT.parity_cv);
    d.acc.ccv_cnt = inc8(q.acc.ccv_cnt, LINE_EVT.cbit_cv);

    // violation counters count every event, parity and C-bit ones only in the DS3 modes
    d.cnt[CNT_LCV] = inc_sat(q.cnt[CNT_LCV], LINE_EVT.line_cv);
    d.cnt[CNT_PCV] = inc_sat(q.cnt[CNT_PCV], ds3 && LINE_EVT.parity_cv);
    d.cnt[CNT_CCV] = inc_sat(q.cnt[CNT_CCV], ds3 && LINE_EVT.cbit_cv);

    // seconds counters at each second boundary
    if (sec_tick) begin
      prev_sec_err = q.acc.oof || q.acc.ais;
      d.cnt[CNT_PES] = inc_sat(q.cnt[CNT_PES], ds3 && (q.acc.pcv || prev_sec_err));
      d.cnt[CNT_PSES] = inc_sat(q.cnt[CNT_PSES],
        ds3 && (q.acc.pcv_cnt >= SES_PCV_LIMIT || prev_sec_err));
      d.cnt[CNT_SEFS] = inc_sat(q.cnt[CNT_SEFS], q.acc.oof);
      d.cnt[CNT_UAS] = inc_sat(q.cnt[CNT_UAS],
        q.acc.oof || q.acc.ais || q.acc.rai);
      d.cnt[CNT_LES] = inc_sat(q.cnt[CNT_LES], q.acc.lcv);
      d.cnt[CNT_CES] = inc_sat(q.cnt[CNT_CES], cbit && q.acc.ccv);
      d.cnt[CNT_CSES] = inc_sat(q.cnt[CNT_CSES],
        cbit && (q.acc.ccv_cnt >= SES_CCV_LIMIT || prev_sec_err));
      d.acc = '0;
    end

    // interval boundary restarts every counter
    if (int_tick) begin
      d.cnt = '0;
    end

    // read data, registered in the data phase
    d.rdata = 32'h0000_0000;
    if (d.req.hit && !HWRITE) begin
      case (HADDR[7:0])
        OFS_LINE_CFG:    sel = {30'h0, q.mode};
        OFS_LOOP_SEL:    sel = {29'h0, q.loopback_select};
        OFS_TX_TIMING:   sel = {30'h0, q.tx_timing_select};
        OFS_COND_WORD:   sel = {24'h0, cond_word};
        OFS_CFG_ERR:     sel = {29'h0, q.cfg_err};
        OFS_IFACE_IDX:   sel = {16'h0, q.line_interface_index};
        OFS_CUR_IDX:     sel = {16'h0, q.cur_interface_index};
        OFS_SECS_IN_INT: sel = {22'h0, secs_done};
        default: begin
          if (HADDR[7:0] >= OFS_CNT_BASE &&
              HADDR[7:0] < OFS_CNT_BASE + 8'(NUM_CNT * 4) && HADDR[1:0] == 2'b00) begin
            sel = q.cnt[4'(HADDR[7:2] - OFS_CNT_BASE[7:2])];
          end else begin
            sel = 32'h0000_0000;
          end
        end
      endcase
      d.rdata = sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      q <= '0;
      q.mode <= MODE_DS3_CBIT;
      q.loopback_select <= LOOP_NONE;
      q.tx_timing_select <= TIMING_INTERNAL;
      q.line_interface_index <= IFACE_IDX_RST;
      q.cur_interface_index <= IFACE_IDX_RST;
    end else begin
      q <= d;
    end
  end

  assign HRDATA           = q.rdata;
  assign HREADYOUT        = 1'b1;
  assign HRESP            = 1'b0;
  assign LINE_MODE        = q.mode;
  assign PAYLOAD_LOOP_EN  = q.pl_loop;
  assign LINE_LOOP_EN     = q.ln_loop;
  assign TX_CLK_RECOVERED = q.tx_rec;
  assign INTERVAL_DONE    = q.int_done;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  property p_loop_other_rejected;
    @(posedge CLK) disable iff (!RST_B)
    (q.req.hit && q.req.write && q.req.addr == OFS_LOOP_SEL && HWDATA[2:0] == LOOP_OTHER)
      |=> (q.cfg_err[ERR_LOOP_BIT] && $stable(q.loopback_select));
  endproperty
  a_loop_other_rejected: assert property (p_loop_other_rejected)
    else $error("loopback code 4 not rejected");

  property p_loop_exclusive;
    @(posedge CLK) disable iff (!RST_B)
    !(q.pl_loop && q.ln_loop) && (q.loopback_select == LOOP_NONE) == !(q.pl_loop || q.ln_loop);
  endproperty
  a_loop_exclusive: assert property (p_loop_exclusive)
    else $error("loopback enables disagree with selection");

  property p_cond_loop_flag;
    @(posedge CLK) disable iff (!RST_B)
    cond_word[7] == (q.pl_loop || q.ln_loop) && cond_word[4] == 1'b0;
  endproperty
  a_cond_loop_flag: assert property (p_cond_loop_flag)
    else $error("loopback flag wrong in condition word");

  property p_cond_no_alarm;
    @(posedge CLK) disable iff (!RST_B)
    cond_word[0] == (cond_word[6:1] == 6'h00);
  endproperty
  a_cond_no_alarm: assert property (p_cond_no_alarm)
    else $error("no-alarm flag inconsistent");

  property p_timing;
    @(posedge CLK) disable iff (!RST_B)
    TX_CLK_RECOVERED == (q.tx_timing_select == TIMING_RECOVERED);
  endproperty
  a_timing: assert property (p_timing)
    else $error("transmit timing output mismatch");

  property p_e3_parity_frozen;
    @(posedge CLK) disable iff (!RST_B)
    (q.mode == MODE_E3 && !int_tick) |=> ($stable(q.cnt[CNT_PES]) && $stable(q.cnt[CNT_PCV]));
  endproperty
  a_e3_parity_frozen: assert property (p_e3_parity_frozen)
    else $error("parity counter moved in E3 mode");

  property p_m13_cbit_frozen;
    @(posedge CLK) disable iff (!RST_B)
    (q.mode != MODE_DS3_CBIT && !int_tick) |=> $stable(q.cnt[CNT_CES]);
  endproperty
  a_m13_cbit_frozen: assert property (p_m13_cbit_frozen)
    else $error("C-bit errored seconds moved outside C-bit mode");

  property p_sefs_on_oof;
    @(posedge CLK) disable iff (!RST_B)
    (sec_tick && q.acc.oof && !int_tick && q.cnt[CNT_SEFS] != 32'hFFFF_FFFF)
      |=> q.cnt[CNT_SEFS] == $past(q.cnt[CNT_SEFS]) + 32'h0000_0001;
  endproperty
  a_sefs_on_oof: assert property (p_sefs_on_oof)
    else $error("framing second not counted");

  property p_lcv_count;
    @(posedge CLK) disable iff (!RST_B)
    (LINE_EVT.line_cv && !int_tick && q.cnt[CNT_LCV] != 32'hFFFF_FFFF)
      |=> q.cnt[CNT_LCV] == $past(q.cnt[CNT_LCV]) + 32'h0000_0001;
  endproperty
  a_lcv_count: assert property (p_lcv_count)
    else $error("line code violation not counted");

  property p_index_tag;
    @(posedge CLK) disable iff (!RST_B)
    ##1 q.cur_interface_index == q.line_interface_index;
  endproperty
  a_index_tag: assert property (p_index_tag)
    else $error("counter set index differs from line index");

  property p_interval_clear;
    @(posedge CLK) disable iff (!RST_B)
    int_tick |=> (q.cnt == '0 && INTERVAL_DONE);
  endproperty
  a_interval_clear: assert property (p_interval_clear)
    else $error("counters not cleared at interval boundary");

  c_payload_loop: cover property (@(posedge CLK) disable iff (!RST_B) $rose(PAYLOAD_LOOP_EN));
  c_uas_second: cover property (@(posedge CLK) disable iff (!RST_B) sec_tick && q.acc.ais);
  c_interval_end: cover property (@(posedge CLK) disable iff (!RST_B) int_tick);
  c_multi_flag: cover property (@(posedge CLK) disable iff (!RST_B) cond_word[5] && cond_word[6]);
endmodule

//--- lpm_pkg.sv
// package: register map, field layout, modes and timing for the line monitor
package lpm_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_LINE_CFG    = 8'h00;
  localparam logic [7:0] OFS_LOOP_SEL    = 8'h04;
  localparam logic [7:0] OFS_TX_TIMING   = 8'h08;
  localparam logic [7:0] OFS_COND_WORD   = 8'h0C;
  localparam logic [7:0] OFS_CFG_ERR     = 8'h10;
  localparam logic [7:0] OFS_IFACE_IDX   = 8'h14;
  localparam logic [7:0] OFS_CUR_IDX     = 8'h18;
  localparam logic [7:0] OFS_SECS_IN_INT = 8'h1C;
  localparam logic [7:0] OFS_CNT_BASE    = 8'h20;
  localparam int         NUM_CNT         = 10;

  // counter slots, in map order from OFS_CNT_BASE
  localparam int CNT_PES  = 0;
  localparam int CNT_PSES = 1;
  localparam int CNT_SEFS = 2;
  localparam int CNT_UAS  = 3;
  localparam int CNT_LCV  = 4;
  localparam int CNT_PCV  = 5;
  localparam int CNT_LES  = 6;
  localparam int CNT_CCV  = 7;
  localparam int CNT_CES  = 8;
  localparam int CNT_CSES = 9;

  // loopback selection codes
  localparam logic [2:0] LOOP_NONE    = 3'h1;
  localparam logic [2:0] LOOP_PAYLOAD = 3'h2;
  localparam logic [2:0] LOOP_LINE    = 3'h3;
  localparam logic [2:0] LOOP_OTHER   = 3'h4;

  // transmit timing codes
  localparam logic [1:0] TIMING_RECOVERED = 2'h1;
  localparam logic [1:0] TIMING_INTERNAL  = 2'h2;

  // line condition word weights
  localparam logic [7:0] COND_NO_ALARM = 8'h01;
  localparam logic [7:0] COND_RX_RAI   = 8'h02;
  localparam logic [7:0] COND_TX_RAI   = 8'h04;
  localparam logic [7:0] COND_RX_AIS   = 8'h08;
  localparam logic [7:0] COND_LOF      = 8'h20;
  localparam logic [7:0] COND_LOS      = 8'h40;
  localparam logic [7:0] COND_LOOP     = 8'h80;

  // config error flag bits
  localparam int ERR_LOOP_BIT   = 0;
  localparam int ERR_TIMING_BIT = 1;
  localparam int ERR_MODE_BIT   = 2;

  // reset values
  localparam logic [15:0] IFACE_IDX_RST = 16'h0001;

  // timing
  localparam longint CLK_HZ        = 250_000_000;
  localparam longint SECOND_NS     = 1_000_000_000;
  localparam longint CLK_PERIOD_NS = SECOND_NS / CLK_HZ;
  localparam longint SEC_CYCLES    = SECOND_NS / CLK_PERIOD_NS;
  localparam int     INTERVAL_MIN  = 15;
  localparam int     INTERVAL_SECS = INTERVAL_MIN * 60;

  // line modes
  typedef enum logic [1:0] {
    MODE_DS3_M13  = 2'b00,
    MODE_DS3_CBIT = 2'b01,
    MODE_E3       = 2'b10
  } line_mode_t;

  // per-cycle error and alarm indications from the line
  typedef struct packed {
    logic los;
    logic lof;
    logic ais;
    logic rx_rai;
    logic tx_rai;
    logic line_cv;
    logic parity_cv;
    logic cbit_cv;
  } line_evt_t;

  // per-second error latches
  typedef struct packed {
    logic lcv;
    logic pcv;
    logic ccv;
    logic oof;
    logic ais;
    logic rai;
    logic [7:0] pcv_cnt;
    logic [7:0] ccv_cnt;
  } sec_acc_t;

  localparam logic [7:0] SES_PCV_LIMIT = 8'h2C;
  localparam logic [7:0] SES_CCV_LIMIT = 8'h2C;

  typedef struct packed {
    logic        hit;
    logic        write;
    logic [7:0]  addr;
  } bus_req_t;

endpackage

//--- lpm_sec_timer.sv
// one-second and fifteen-minute boundary timer
`timescale 1ns/1ns
module lpm_sec_timer #(
  parameter longint SEC_CYCLES_P = lpm_pkg::SEC_CYCLES
) (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_B,
  // boundaries
  output logic             SEC_TICK,
  output logic             INT_TICK,
  output logic [9:0]       SECS_DONE
);
  import lpm_pkg::*;

  typedef struct packed {
    logic [31:0] cyc;
    logic [9:0]  secs;
    logic        sec_tick;
    logic        int_tick;
  } tmr_t;

  tmr_t q, d;

  always_comb begin
    d = q;
    d.sec_tick = 1'b0;
    d.int_tick = 1'b0;
    if (q.cyc == 32'(SEC_CYCLES_P - 1)) begin
      d.cyc = 32'h0000_0000;
      d.sec_tick = 1'b1;
      if (q.secs == 10'(INTERVAL_SECS - 1)) begin
        d.secs = 10'h000;
        d.int_tick = 1'b1;
      end else begin
        d.secs = q.secs + 10'h001;
      end
    end else begin
      d.cyc = q.cyc + 32'h0000_0001;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign SEC_TICK  = q.sec_tick;
  assign INT_TICK  = q.int_tick;
  assign SECS_DONE = q.secs;
endmodule

//--- lpm_line_model.sv
// far-side line model: alarm levels and one-cycle violation pulses
`timescale 1ns/1ns
module lpm_line_model (
  // clock and reset
  input  wire logic          CLK,
  input  wire logic          RST_B,
  // commands from the bench
  input  wire logic [4:0]    alarm_lvl,
  input  wire logic [2:0]    cv_sel,
  input  wire logic [7:0]    cv_num,
  input  wire logic          cv_go,
  // line side
  output lpm_pkg::line_evt_t LINE_EVT,
  output logic               cv_busy
);
  import lpm_pkg::*;
  logic [7:0] left_q;
  assign cv_busy = cv_go || (left_q != 8'h00);
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      left_q   <= 8'h00;
      LINE_EVT <= '0;
    end else begin
      {LINE_EVT.los, LINE_EVT.lof, LINE_EVT.ais} <= alarm_lvl[4:2];
      {LINE_EVT.rx_rai, LINE_EVT.tx_rai} <= alarm_lvl[1:0];
      // one pulse per violation, at most one of each kind a cycle
      {LINE_EVT.line_cv, LINE_EVT.parity_cv, LINE_EVT.cbit_cv} <=
        (left_q != 8'h00) ? cv_sel : 3'h0;
      if (cv_go) begin
        left_q <= cv_num;
      end else if (left_q != 8'h00) begin
        left_q <= left_q - 8'h01;
      end
    end
  end
endmodule

//--- test_ds3_e3_line_perf_monitor.sv
// self-checking bench for the line monitor
`timescale 1ns/1ns
module test_ds3_e3_line_perf_monitor;
  import lpm_pkg::*;
  localparam int SEC_C = 20;
  logic        CLK = 1'b0;
  logic        RST_B = 1'b0;
  logic        HSEL = 1'b0;
  logic [31:0] HADDR = 32'h0;
  logic [1:0]  HTRANS = 2'h0;
  logic        HWRITE = 1'b0;
  logic [31:0] HWDATA = 32'h0;
  logic [31:0] HRDATA;
  logic        HREADYOUT;
  logic        HRESP;
  line_evt_t   LINE_EVT;
  line_mode_t  LINE_MODE;
  logic        PAYLOAD_LOOP_EN;
  logic        LINE_LOOP_EN;
  logic        TX_CLK_RECOVERED;
  logic        INTERVAL_DONE;
  logic [4:0]  alarm_lvl = 5'h0;
  logic [2:0]  cv_sel = 3'h0;
  logic [7:0]  cv_num = 8'h0;
  logic        cv_go = 1'b0;
  logic        cv_busy;
  int          fail_count = 0;
  int          n_checks = 0;
  int          cyc = 0;
  logic [31:0] seed = 32'h2E13;
  logic [31:0] v;
  logic [31:0] b_v [NUM_CNT];
  logic [31:0] n_v [NUM_CNT];
  always #2 CLK = ~CLK;
  always @(posedge CLK) if (RST_B) cyc <= cyc + 1;
  lpm_line_monitor #(.SEC_CYCLES_P(SEC_C)) i_lpm_line_monitor (
    .CLK(CLK), .RST_B(RST_B), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .LINE_EVT(LINE_EVT),
    .LINE_MODE(LINE_MODE), .PAYLOAD_LOOP_EN(PAYLOAD_LOOP_EN),
    .LINE_LOOP_EN(LINE_LOOP_EN), .TX_CLK_RECOVERED(TX_CLK_RECOVERED),
    .INTERVAL_DONE(INTERVAL_DONE));
  lpm_line_model i_lpm_line_model (
    .CLK(CLK), .RST_B(RST_B), .alarm_lvl(alarm_lvl), .cv_sel(cv_sel),
    .cv_num(cv_num), .cv_go(cv_go), .LINE_EVT(LINE_EVT), .cv_busy(cv_busy));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [7:0] exp_cond(logic [4:0] a, logic lp);
    logic [7:0] w;
    w = (a == 5'h0) ? COND_NO_ALARM : 8'h00;
    w = w + (a[4] ? COND_LOS : 8'h00) + (a[3] ? COND_LOF : 8'h00);
    w = w + (a[2] ? COND_RX_AIS : 8'h00) + (a[1] ? COND_RX_RAI : 8'h00);
    w = w + (a[0] ? COND_TX_RAI : 8'h00) + (lp ? COND_LOOP : 8'h00);
    return w;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] lo,
                     input logic [31:0] hi, input string what);
    logic ok;
    ok = (got >= lo) && (got <= hi);
    n_checks++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s got %0h want %0h..%0h", $time, what, got, lo, hi);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLK);
    HSEL   <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= w;
    HADDR  <= {24'h0, a};
    do @(posedge CLK); while (HREADYOUT !== 1'b1 && n++ < 50);
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge CLK); while (HREADYOUT !== 1'b1 && n++ < 50);
    v = HRDATA;
    HSEL <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge CLK);
  endtask
  task automatic rd_all(input bit to_base);
    for (int i = 0; i < NUM_CNT; i++) begin
      rd(OFS_CNT_BASE + 8'(4 * i));
      if (to_base) b_v[i] = v;
      else n_v[i] = v;
    end
  endtask
  function automatic logic [31:0] dl(int i);
    return n_v[i] - b_v[i];
  endfunction
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #120000;
    fail_count++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    conclude();
  end
  initial begin
    logic [2:0] lc [9] = '{3'h2, 3'h4, 3'h3, 3'h0, 3'h1, 3'h5, 3'h2, 3'h7, 3'h1};
    logic [1:0] tc [6] = '{2'h1, 2'h3, 2'h2, 2'h0, 2'h1, 2'h2};
    logic       pl;
    logic       ll;
    logic       rc;
    logic       bad;
    logic [4:0] alm;
    logic [15:0] idx;
    logic [7:0] n;
    int         m;
    idle(20);
    RST_B <= 1'b1;
    chk({30'h0, LINE_MODE}, 32'h1, 32'h1, "reset mode");
    chk({29'h0, PAYLOAD_LOOP_EN, LINE_LOOP_EN, TX_CLK_RECOVERED}, 0, 0, "reset out");
    rd(OFS_CUR_IDX);
    chk(v, 32'h1, 32'h1, "reset cur idx");
    chk({31'h0, HRESP}, 0, 0, "hresp");
    rd(8'h48);
    chk(v, 0, 0, "unmapped");
    idx = 16'(xs()) | 16'h1;
    wr(OFS_IFACE_IDX, {16'h0, idx});
    wr(OFS_CUR_IDX, 32'h0);
    rd(OFS_CUR_IDX);
    chk(v, {16'h0, idx}, {16'h0, idx}, "cur idx");
    $display("test registers done");
    alarm_lvl <= 5'h10;
    pl = 1'b0;
    ll = 1'b0;
    foreach (lc[k]) begin
      wr(OFS_CFG_ERR, 32'h7);
      wr(OFS_LOOP_SEL, {29'h0, lc[k]});
      bad = !(lc[k] >= 3'h1 && lc[k] <= 3'h3);
      if (!bad) pl = (lc[k] == LOOP_PAYLOAD);
      if (!bad) ll = (lc[k] == LOOP_LINE);
      rd(OFS_CFG_ERR);
      chk({31'h0, v[ERR_LOOP_BIT]}, {31'h0, bad}, {31'h0, bad}, "loop err");
      chk({30'h0, PAYLOAD_LOOP_EN, LINE_LOOP_EN}, {pl, ll}, {pl, ll}, "loop");
      rd(OFS_COND_WORD);
      chk(v, exp_cond(5'h10, pl | ll), exp_cond(5'h10, pl | ll), "cond");
    end
    $display("test loopback done");
    rc = 1'b0;
    foreach (tc[k]) begin
      wr(OFS_CFG_ERR, 32'h7);
      wr(OFS_TX_TIMING, {30'h0, tc[k]});
      bad = !(tc[k] == TIMING_RECOVERED || tc[k] == TIMING_INTERNAL);
      if (!bad) rc = (tc[k] == TIMING_RECOVERED);
      rd(OFS_CFG_ERR);
      chk({31'h0, v[ERR_TIMING_BIT]}, {31'h0, bad}, {31'h0, bad}, "tim err");
      chk({31'h0, TX_CLK_RECOVERED}, {31'h0, rc}, {31'h0, rc}, "timing");
    end
    $display("test timing done");
    wr(OFS_CFG_ERR, 32'h7);
    wr(OFS_LINE_CFG, 32'h3);
    rd(OFS_CFG_ERR);
    chk({31'h0, v[ERR_MODE_BIT]}, 1, 1, "mode err");
    rd(OFS_LINE_CFG);
    chk(v, 32'h1, 32'h1, "mode kept");
    wr(OFS_LOOP_SEL, 32'h1);
    for (int k = 0; k < 12; k++) begin
      alm = 5'(xs()) & 5'h1D;
      alarm_lvl <= alm;
      idle(3);
      rd(OFS_COND_WORD);
      chk(v, exp_cond(alm, 1'b0), exp_cond(alm, 1'b0), "cond sum");
    end
    alarm_lvl <= 5'h02;
    idle(3);
    rd(OFS_COND_WORD);
    chk(v, 32'h2, 32'h2, "cond rai");
    alarm_lvl <= 5'h00;
    idle(3 * SEC_C);
    rd(OFS_COND_WORD);
    chk(v, 32'h1, 32'h1, "cond none");
    $display("test condition done");
    for (m = 0; m < 3; m++) begin
      wr(OFS_LINE_CFG, 32'(m));
      rd(OFS_LINE_CFG);
      chk(v, 32'(m), 32'(m), "mode");
      chk({30'h0, LINE_MODE}, 32'(m), 32'(m), "mode out");
      rd_all(1'b1);
      alarm_lvl <= (m == 0) ? 5'h08 : (m == 1) ? 5'h04 : 5'h02;
      idle(2 * SEC_C);
      alarm_lvl <= 5'h00;
      idle(3 * SEC_C);
      rd_all(1'b0);
      chk(dl(CNT_UAS), 2, 3, "uas");
      chk(dl(CNT_SEFS), (m == 0) ? 2 : 0, (m == 0) ? 3 : 0, "sefs");
      chk(dl(CNT_PES), (m < 2) ? 2 : 0, (m < 2) ? 3 : 0, "pes alarm");
      chk(dl(CNT_PSES), (m < 2) ? 2 : 0, (m < 2) ? 3 : 0, "pses");
      n = 8'd3 + 8'(xs() % 18);
      rd_all(1'b1);
      @(posedge CLK);
      cv_sel <= 3'h7;
      cv_num <= n;
      cv_go <= 1'b1;
      @(posedge CLK);
      cv_go <= 1'b0;
      idle(3 * SEC_C);
      rd_all(1'b0);
      chk(dl(CNT_LCV), n, n, "lcv");
      chk(dl(CNT_PCV), (m < 2) ? n : 0, (m < 2) ? n : 0, "pcv");
      chk(dl(CNT_CCV), (m < 2) ? n : 0, (m < 2) ? n : 0, "ccv");
      chk(dl(CNT_LES), 1, 2, "les");
      chk(dl(CNT_PES), (m < 2) ? 1 : 0, (m < 2) ? 2 : 0, "pes cv");
      chk(dl(CNT_CES), (m == 1) ? 1 : 0, (m == 1) ? 2 : 0, "ces");
      chk(dl(CNT_CSES), 0, 0, "cses");
    end
    $display("test counters done");
    m = 0;
    while (INTERVAL_DONE !== 1'b1 && m < 20000) begin
      @(posedge CLK);
      m++;
    end
    chk(cyc, 900 * SEC_C - 2, 900 * SEC_C + 3, "interval length");
    rd_all(1'b0);
    foreach (n_v[i]) chk(n_v[i], 0, 0, "cleared");
    rd(OFS_SECS_IN_INT);
    chk(v, 0, 1, "secs");
    $display("test interval done");
    conclude();
  end
endmodule
